/* File: hw/xbar_pkg.sv */
// Shared constants, types and helper functions for the crossbar system
package xbar_pkg;

    // Port counts and path widths (data may be set to 8, 16, 32 or 64)
    localparam int NUM_M     = 2;
    localparam int NUM_S     = 2;
    localparam int DAT_W     = 32;
    localparam int ADR_W     = 32;
    localparam int SEL_W     = DAT_W / 8;
    localparam int TAG_W     = 1;
    localparam int SID_W     = 1;
    localparam int MIDX_W    = 1;
    localparam int CNT_W     = 2;

    // Example slave memory and timing
    localparam int MEM_DEPTH = 16;
    localparam int MIDX_LO   = 2;
    localparam int MEM_IDX_W = 4;
    localparam logic [3:0]       SLV_WAIT = 4'h1;
    localparam logic [ADR_W-1:0] ADR_STEP = 32'h0000_0004;

    // Values after reset
    localparam logic [ADR_W-1:0] ADR_RST  = 32'h0000_0000;
    localparam logic [DAT_W-1:0] DAT_RST  = 32'h0000_0000;

    // Transfer outcome reported to the user
    localparam logic [1:0] ST_OK  = 2'h0;
    localparam logic [1:0] ST_ERR = 2'h1;
    localparam logic [1:0] ST_RTY = 2'h2;

    typedef enum logic [1:0] {
        M_IDLE  = 2'b01,
        M_PHASE = 2'b10
    } mstate_t;

    // Slave index is taken from the top address bits
    function automatic logic [SID_W-1:0] slave_of(
        input logic [ADR_W-1:0] adr);
        return adr[ADR_W-1 -: SID_W];
    endfunction

    function automatic logic [MEM_IDX_W-1:0] word_idx(
        input logic [ADR_W-1:0] adr);
        return adr[MIDX_LO +: MEM_IDX_W];
    endfunction

    function automatic logic in_range(input logic [ADR_W-1:0] adr);
        return adr[ADR_W-SID_W-1 : MIDX_LO+MEM_IDX_W] == '0;
    endfunction

endpackage

/* File: hw/bus_link.sv */
// Wiring between the crossbar fabric and the master and slave cores
`timescale 1ns/1ns
interface bus_link;
    import xbar_pkg::*;

    // Master ports
    logic [NUM_M-1:0] m_cyc;
    logic [NUM_M-1:0] m_stb;
    logic [NUM_M-1:0] m_we;
    logic [NUM_M-1:0] m_ack;
    logic [NUM_M-1:0] m_err;
    logic [NUM_M-1:0] m_rty;
    logic [ADR_W-1:0] m_adr  [NUM_M];
    logic [DAT_W-1:0] m_wdat [NUM_M];
    logic [DAT_W-1:0] m_rdat [NUM_M];
    logic [SEL_W-1:0] m_sel  [NUM_M];
    logic [TAG_W-1:0] m_tag  [NUM_M];

    // Slave ports
    logic [NUM_S-1:0] s_cyc;
    logic [NUM_S-1:0] s_stb;
    logic [NUM_S-1:0] s_we;
    logic [NUM_S-1:0] s_ack;
    logic [NUM_S-1:0] s_err;
    logic [NUM_S-1:0] s_rty;
    logic [ADR_W-1:0] s_adr  [NUM_S];
    logic [DAT_W-1:0] s_wdat [NUM_S];
    logic [DAT_W-1:0] s_rdat [NUM_S];
    logic [SEL_W-1:0] s_sel  [NUM_S];
    logic [TAG_W-1:0] s_tag  [NUM_S];

    modport fabric (
        input  m_cyc, m_stb, m_we, m_adr, m_wdat, m_sel, m_tag,
        output m_ack, m_err, m_rty, m_rdat,
        output s_cyc, s_stb, s_we, s_adr, s_wdat, s_sel, s_tag,
        input  s_ack, s_err, s_rty, s_rdat
    );

    modport agents (
        output m_cyc, m_stb, m_we, m_adr, m_wdat, m_sel, m_tag,
        input  m_ack, m_err, m_rty, m_rdat,
        input  s_cyc, s_stb, s_we, s_adr, s_wdat, s_sel, s_tag,
        output s_ack, s_err, s_rty, s_rdat
    );

endinterface

/* File: hw/xbar_arbiter.sv */
// Round-robin arbiter that owns one slave port of the crossbar
`timescale 1ns/1ns
module xbar_arbiter (
    // Clock and reset
    input  wire logic                       clk_in,
    input  wire logic                       rst_in,
    // Requests, one bit per master
    input  wire logic [xbar_pkg::NUM_M-1:0] req_in,
    // Grant
    output logic                            valid_out,
    output logic [xbar_pkg::MIDX_W-1:0]     owner_out
);
    import xbar_pkg::*;

    logic [MIDX_W-1:0] next_owner;

    // Search starts after the current owner so nobody starves
    always_comb begin
        int cand;
        logic found;
        cand = 0;
        found = 1'b0;
        next_owner = owner_out;
        for (int i = 1; i <= NUM_M; i++) begin
            cand = (int'(owner_out) + i) % NUM_M;
            if (req_in[cand] && !found) begin
                found = 1'b1;
                next_owner = MIDX_W'(cand);
            end
        end
    end

    // Grant holds while the owner keeps its cycle up
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            valid_out <= 1'b0;
            owner_out <= '0;
        end else if (!valid_out || !req_in[owner_out]) begin
            valid_out <= |req_in;
            owner_out <= next_owner;
        end
    end

endmodule

/* File: hw/xbar_fabric.sv */
// Crossbar fabric joining every master port to every slave port
//
// Summary of operation
// - Masters on different slaves run concurrently
// - Master must win arbitration before proceeding
// - Granted pair uses its own private path
// - Slave ends transfer: ack, error or retry
// - Ack is mandatory; error, retry optional
// - Either party may stretch any phase
// - Port signals are pure inputs or outputs
// - Data 8 to 64 bits, address 0-64
// - User tag signals travel with each port
// - Single, block and read-modify-write supported
// - Master starts read: address, strobe, cycle
// - Slave decodes strobe and address, drives data
// - Slave acks only with valid data
// - Master samples ack, latches data, drops strobe (strobe stays up between block and RMW phases here)
// - Write: slave acks after capturing data
// - Block cycle is consecutive phases, one cycle
// - Cycle signal stays up across all phases
// - Cycle up requests, cycle down releases
// - Master and slave ports pair one-to-one
// - Owned slave not regranted until release

`timescale 1ns/1ns
module xbar_fabric (
    // Clock and reset
    input  wire logic                             MCLK_IN,
    input  wire logic                             SYS_RST_IN,
    // Master and slave ports
    bus_link.fabric                               BUS,
    // Status
    output logic [xbar_pkg::NUM_S-1:0]            SLAVE_BUSY_OUT,
    output logic [xbar_pkg::NUM_S-1:0]
                 [xbar_pkg::MIDX_W-1:0]           SLAVE_OWNER_OUT,
    output logic [xbar_pkg::CNT_W-1:0]            ACTIVE_PAIRS_OUT
);
    import xbar_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Request decode and arbitration

    // Per slave
    logic [NUM_M-1:0]  req        [NUM_S];
    logic [NUM_S-1:0]  gnt_valid;
    logic [MIDX_W-1:0] owner      [NUM_S];

    // Phase state
    logic [NUM_S-1:0]  live;
    logic [NUM_S-1:0]  term;
    logic [NUM_M-1:0]  answered;

    // Live pairs, for the status output
    function automatic logic [CNT_W-1:0] count_ones(
        input logic [NUM_S-1:0] v);
        logic [CNT_W-1:0] n;
        n = '0;

        for (int i = 0; i < NUM_S; i++) begin
            n = n + CNT_W'(v[i]);
        end
        return n;
    endfunction

    // Any outcome ends a phase
    function automatic logic ended(input logic a, e, r);
        return a | e | r;
    endfunction

    // An asserted cycle is a request to the slave its address selects
    // Changing slave mid-cycle drops the grant
    always_comb begin
        for (int s = 0; s < NUM_S; s++) begin
            for (int m = 0; m < NUM_M; m++) begin
                req[s][m] = BUS.m_cyc[m] &&
                    (slave_of(BUS.m_adr[m]) == SID_W'(s));
            end
        end
    end

    always_comb begin
        for (int s = 0; s < NUM_S; s++) begin
            live[s] = gnt_valid[s] && req[s][owner[s]];
            term[s] = ended(BUS.s_ack[s], BUS.s_err[s], BUS.s_rty[s]);
        end
    end

    // A master's strobe is stale in the cycle it is being answered,
    // since it has not yet seen the answer; forwarding it would repeat
    // the phase
    always_comb begin
        for (int m = 0; m < NUM_M; m++) begin
            answered[m] = ended(BUS.m_ack[m], BUS.m_err[m], BUS.m_rty[m]);
        end
    end

    // One independent arbiter per slave lets pairs run in parallel
    for (genvar gs = 0; gs < NUM_S; gs++) begin : g_arb
        xbar_arbiter u_arb (
            .clk_in    (MCLK_IN),
            .rst_in    (SYS_RST_IN),
            .req_in    (req[gs]),
            .valid_out (gnt_valid[gs]),
            .owner_out (owner[gs])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // Master to slave path

    // Each slave port carries only its owner's signals, so no two pairs
    // ever share wiring; the register adds one cycle each way
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            BUS.s_cyc <= '0;
            BUS.s_stb <= '0;
            BUS.s_we  <= '0;

            for (int s = 0; s < NUM_S; s++) begin
                BUS.s_adr[s]  <= ADR_RST;
                BUS.s_wdat[s] <= DAT_RST;
                BUS.s_sel[s]  <= '0;
                BUS.s_tag[s]  <= '0;
            end
        end else begin
            for (int s = 0; s < NUM_S; s++) begin
                BUS.s_cyc[s] <= live[s];

                if (!live[s]) begin
                    // Owner gone: abandon any phase still open
                    BUS.s_stb[s] <= 1'b0;
                end else if (BUS.s_stb[s] && term[s]) begin
                    // No repeat
                    BUS.s_stb[s] <= 1'b0;
                end else if (!BUS.s_stb[s] && BUS.m_stb[owner[s]] &&
                             !answered[owner[s]]) begin
                    BUS.s_stb[s]  <= 1'b1;
                    BUS.s_we[s]   <= BUS.m_we[owner[s]];
                    BUS.s_adr[s]  <= BUS.m_adr[owner[s]];
                    BUS.s_wdat[s] <= BUS.m_wdat[owner[s]];
                    BUS.s_sel[s]  <= BUS.m_sel[owner[s]];
                    BUS.s_tag[s]  <= BUS.m_tag[owner[s]];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Slave to master path

    // Answers are routed by owner only; a waiting master sees nothing.
    // A slave that stalls simply delays the answer, which in turn
    // stalls the master.
    // An answer meeting an abort is lost
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            BUS.m_ack <= '0;
            BUS.m_err <= '0;
            BUS.m_rty <= '0;

            for (int m = 0; m < NUM_M; m++) begin
                BUS.m_rdat[m] <= DAT_RST;
            end
        end else begin
            BUS.m_ack <= '0;
            BUS.m_err <= '0;
            BUS.m_rty <= '0;

            for (int s = 0; s < NUM_S; s++) begin
                for (int m = 0; m < NUM_M; m++) begin
                    if (live[s] && owner[s] == MIDX_W'(m) &&
                        BUS.s_stb[s] && term[s]) begin
                        BUS.m_ack[m]  <= BUS.s_ack[s];
                        BUS.m_err[m]  <= BUS.s_err[s];
                        BUS.m_rty[m]  <= BUS.s_rty[s];
                        BUS.m_rdat[m] <= BUS.s_rdat[s];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            SLAVE_BUSY_OUT   <= '0;
            ACTIVE_PAIRS_OUT <= '0;

            for (int s = 0; s < NUM_S; s++) begin
                SLAVE_OWNER_OUT[s] <= '0;
            end
        end else begin
            // Trails live by one cycle
            SLAVE_BUSY_OUT   <= live;
            ACTIVE_PAIRS_OUT <= count_ones(live);

            for (int s = 0; s < NUM_S; s++) begin
                SLAVE_OWNER_OUT[s] <= owner[s];
            end
        end
    end

endmodule

/* File: hw/bus_agents.sv */
// Master and slave cores that sit on the far side of the crossbar
`timescale 1ns/1ns
module bus_agents (
    // Clock and reset
    input  wire logic                                   MCLK_IN,
    input  wire logic                                   SYS_RST_IN,
    // Master and slave ports
    bus_link.agents                                     BUS,
    // Master commands
    input  wire logic [xbar_pkg::NUM_M-1:0]             CMD_GO_IN,
    input  wire logic [xbar_pkg::NUM_M-1:0]             CMD_WE_IN,
    input  wire logic [xbar_pkg::NUM_M-1:0]             CMD_RMW_IN,
    input  wire logic [xbar_pkg::NUM_M-1:0][3:0]        CMD_LEN_IN,
    input  wire logic [xbar_pkg::NUM_M-1:0]
                      [xbar_pkg::ADR_W-1:0]             CMD_ADR_IN,
    input  wire logic [xbar_pkg::NUM_M-1:0]
                      [xbar_pkg::DAT_W-1:0]             CMD_WDAT_IN,
    input  wire logic [xbar_pkg::NUM_M-1:0]
                      [xbar_pkg::SEL_W-1:0]             CMD_SEL_IN,
    input  wire logic [xbar_pkg::NUM_M-1:0]
                      [xbar_pkg::TAG_W-1:0]             CMD_TAG_IN,
    // Master results
    output logic      [xbar_pkg::NUM_M-1:0]             DONE_OUT,
    output logic      [xbar_pkg::NUM_M-1:0][1:0]        STATUS_OUT,
    output logic      [xbar_pkg::NUM_M-1:0]
                      [xbar_pkg::DAT_W-1:0]             RDAT_OUT,
    // Slave control
    input  wire logic [xbar_pkg::NUM_S-1:0]             SLV_RETRY_IN
);
    import xbar_pkg::*;

    mstate_t          mstate_q [NUM_M];
    logic [3:0]       left_q   [NUM_M];
    logic [NUM_M-1:0] rmw_q;
    logic [DAT_W-1:0] mem_q    [NUM_S][MEM_DEPTH];
    logic [3:0]       wait_q   [NUM_S];
    logic [NUM_S-1:0] take;
    logic [NUM_S-1:0] fire;

    ////////////////////////////////////////////////////////////////////
    // Masters

    // Strobe stays up from phase to phase; the fabric ignores it in
    // the cycle its answer is presented
    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            BUS.m_cyc  <= '0;
            BUS.m_stb  <= '0;
            BUS.m_we   <= '0;
            rmw_q      <= '0;
            DONE_OUT   <= '0;
            for (int m = 0; m < NUM_M; m++) begin
                mstate_q[m]    <= M_IDLE;
                left_q[m]      <= '0;
                BUS.m_adr[m]   <= ADR_RST;
                BUS.m_wdat[m]  <= DAT_RST;
                BUS.m_sel[m]   <= '0;
                BUS.m_tag[m]   <= '0;
                STATUS_OUT[m]  <= ST_OK;
                RDAT_OUT[m]    <= DAT_RST;
            end
        end else begin
            for (int m = 0; m < NUM_M; m++) begin
                DONE_OUT[m] <= 1'b0;
                case (mstate_q[m])
                    M_IDLE: begin
                        if (CMD_GO_IN[m]) begin
                            BUS.m_cyc[m]  <= 1'b1;
                            BUS.m_stb[m]  <= 1'b1;
                            BUS.m_we[m]   <= CMD_WE_IN[m] && !CMD_RMW_IN[m];
                            BUS.m_adr[m]  <= CMD_ADR_IN[m];
                            BUS.m_wdat[m] <= CMD_WDAT_IN[m];
                            BUS.m_sel[m]  <= CMD_SEL_IN[m];
                            BUS.m_tag[m]  <= CMD_TAG_IN[m];
                            rmw_q[m]      <= CMD_RMW_IN[m];
                            if (CMD_RMW_IN[m]) begin
                                left_q[m] <= 4'h1;
                            end else if (CMD_LEN_IN[m] == 4'h0) begin
                                left_q[m] <= 4'h0;
                            end else begin
                                left_q[m] <= CMD_LEN_IN[m] - 4'h1;
                            end
                            mstate_q[m] <= M_PHASE;
                        end
                    end
                    M_PHASE: begin
                        if (BUS.m_ack[m] | BUS.m_err[m] | BUS.m_rty[m]) begin
                            if (!BUS.m_we[m]) begin
                                RDAT_OUT[m] <= BUS.m_rdat[m];
                            end
                            if (BUS.m_err[m] || BUS.m_rty[m] ||
                                left_q[m] == 4'h0) begin
                                BUS.m_cyc[m] <= 1'b0;
                                BUS.m_stb[m] <= 1'b0;
                                DONE_OUT[m]  <= 1'b1;
                                STATUS_OUT[m] <= BUS.m_err[m] ? ST_ERR :
                                    (BUS.m_rty[m] ? ST_RTY : ST_OK);
                                mstate_q[m]  <= M_IDLE;
                            end else begin
                                left_q[m] <= left_q[m] - 4'h1;
                                if (rmw_q[m]) begin
                                    BUS.m_we[m] <= 1'b1;
                                end else begin
                                    BUS.m_adr[m] <= BUS.m_adr[m] + ADR_STEP;
                                end
                            end
                        end
                    end
                    default: begin
                        mstate_q[m] <= M_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Slaves

    // Fire once the wait states are spent; take means store a write
    always_comb begin
        for (int s = 0; s < NUM_S; s++) begin
            fire[s] = BUS.s_cyc[s] && BUS.s_stb[s] &&
                !(BUS.s_ack[s] | BUS.s_err[s] | BUS.s_rty[s]) &&
                wait_q[s] == SLV_WAIT;
            take[s] = fire[s] && !SLV_RETRY_IN[s] &&
                in_range(BUS.s_adr[s]) && BUS.s_we[s];
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SYS_RST_IN) begin
            BUS.s_ack <= '0;
            BUS.s_err <= '0;
            BUS.s_rty <= '0;
            for (int s = 0; s < NUM_S; s++) begin
                wait_q[s]     <= '0;
                BUS.s_rdat[s] <= DAT_RST;
            end
        end else begin
            for (int s = 0; s < NUM_S; s++) begin
                BUS.s_ack[s] <= 1'b0;
                BUS.s_err[s] <= 1'b0;
                BUS.s_rty[s] <= 1'b0;
                if (fire[s]) begin
                    wait_q[s] <= '0;
                    if (SLV_RETRY_IN[s]) begin
                        BUS.s_rty[s] <= 1'b1;
                    end else if (!in_range(BUS.s_adr[s])) begin
                        BUS.s_err[s] <= 1'b1;
                    end else begin
                        BUS.s_ack[s]  <= 1'b1;
                        BUS.s_rdat[s] <=
                            mem_q[s][word_idx(BUS.s_adr[s])];
                    end
                end else if (BUS.s_cyc[s] && BUS.s_stb[s] &&
                             !(BUS.s_ack[s] | BUS.s_err[s] |
                               BUS.s_rty[s])) begin
                    wait_q[s] <= wait_q[s] + 4'h1;
                end else begin
                    wait_q[s] <= '0;
                end
            end
        end
    end

    // Write data lands in the same edge that raises the acknowledge
    always_ff @(posedge MCLK_IN) begin
        for (int s = 0; s < NUM_S; s++) begin
            for (int b = 0; b < SEL_W; b++) begin
                if (take[s] && BUS.s_sel[s][b]) begin
                    mem_q[s][word_idx(BUS.s_adr[s])][8*b +: 8] <=
                        BUS.s_wdat[s][8*b +: 8];
                end
            end
        end
    end

endmodule

/* File: tb/xbar_props.sv */
// Concurrent checks on the signals between fabric and agents
`timescale 1ns/1ns
module xbar_props
    import xbar_pkg::*;
(
    // Clock and reset
    input wire logic             MCLK_IN,
    input wire logic             SYS_RST_IN,
    // Master side
    input wire logic [NUM_M-1:0] m_cyc,
    input wire logic [NUM_M-1:0] m_stb,
    input wire logic [NUM_M-1:0] m_ack,
    input wire logic [NUM_M-1:0] m_err,
    input wire logic [NUM_M-1:0] m_rty,
    // Slave side
    input wire logic [NUM_S-1:0] s_cyc,
    input wire logic [NUM_S-1:0] s_stb,
    input wire logic [NUM_S-1:0] s_ack,
    input wire logic [NUM_S-1:0] s_err,
    input wire logic [NUM_S-1:0] s_rty
);
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    logic [NUM_S-1:0] s_ans;
    logic [NUM_M-1:0] m_ans;
    assign s_ans = s_ack | s_err | s_rty;
    assign m_ans = m_ack | m_err | m_rty;

    ////////////////////////////////////////////////////////////////////////
    for (genvar i = 0; i < NUM_M; i++) begin : g_m
        a_ans_latency: assert property (
            m_ans[i] |-> $past(m_cyc[i], 5))
            else $error("Master answered sooner than grant allows");
        a_ans_owner: assert property (
            m_ans[i] |-> m_cyc[i] && m_stb[i] && $past(|s_ans))
            else $error("Master answer without slave answer");
        a_ack_pulse: assert property (m_ack[i] |=> !m_ack[i])
            else $error("Master ack longer than one cycle");
        a_stb_in_cyc: assert property (m_stb[i] |-> m_cyc[i])
            else $error("Master strobe outside cycle");
    end

    ////////////////////////////////////////////////////////////////////////
    // Wait figures assume no abort in mid-phase
    for (genvar j = 0; j < NUM_S; j++) begin : g_s
        a_one_outcome: assert property (
            $onehot0({s_ack[j], s_err[j], s_rty[j]}))
            else $error("Slave gave more than one outcome");
        a_slv_wait: assert property (
            $rose(s_stb[j]) |-> !s_ans[j] ##1 !s_ans[j] ##1 s_ans[j])
            else $error("Slave answer not after one wait state");
        a_phase_gap: assert property (s_ans[j] |=> !s_stb[j] [*2])
            else $error("Slave strobe too soon after answer");
        a_slv_cyc_req: assert property (
            s_cyc[j] |-> $past(|m_cyc))
            else $error("Slave cycle with no master request");
        a_ans_forward: assert property (s_ans[j] |=> |m_ans)
            else $error("Slave answer not passed to a master");
    end

    c_both_ack: cover property (&m_ack);
    c_error:    cover property (|m_err);
    c_retry:    cover property (|m_rty);
    c_two_slv:  cover property (&s_cyc);
endmodule

/* File: tb/testbench.sv */
// Self-checking bench joining fabric and agents through the link
`timescale 1ns/1ns
module testbench;
    import xbar_pkg::*;

    localparam logic [DAT_W-1:0] P0 = 32'hA5A5_0001;
    localparam logic [DAT_W-1:0] P1 = 32'h5A5A_0002;

    logic                        clk;
    logic                        rst;
    logic [NUM_M-1:0]            go;
    logic [NUM_M-1:0]            we;
    logic [NUM_M-1:0]            rmw;
    logic [NUM_M-1:0][3:0]       len;
    logic [NUM_M-1:0][ADR_W-1:0] adr;
    logic [NUM_M-1:0][DAT_W-1:0] wdat;
    logic [NUM_M-1:0][DAT_W-1:0] rdat;
    logic [NUM_M-1:0][SEL_W-1:0] sel;
    logic [NUM_M-1:0][TAG_W-1:0] tag;
    logic [NUM_M-1:0]            done;
    logic [NUM_M-1:0][1:0]       status;
    logic [NUM_S-1:0]            retry;
    logic [NUM_S-1:0]            busy;
    logic [NUM_S-1:0][MIDX_W-1:0] owner;
    logic [CNT_W-1:0]            pairs;
    logic [CNT_W-1:0]            maxp;
    logic [NUM_S-1:0]            bseen;
    int                          tdone [NUM_M];
    int                          failures;
    int                          tests_run;

    bus_link bus_link_i ();
    xbar_fabric xbar_fabric_i (.MCLK_IN(clk), .SYS_RST_IN(rst),
        .BUS(bus_link_i), .SLAVE_BUSY_OUT(busy),
        .SLAVE_OWNER_OUT(owner), .ACTIVE_PAIRS_OUT(pairs));
    bus_agents bus_agents_i (.MCLK_IN(clk), .SYS_RST_IN(rst),
        .BUS(bus_link_i), .CMD_GO_IN(go), .CMD_WE_IN(we),
        .CMD_RMW_IN(rmw), .CMD_LEN_IN(len), .CMD_ADR_IN(adr),
        .CMD_WDAT_IN(wdat), .CMD_SEL_IN(sel), .CMD_TAG_IN(tag),
        .DONE_OUT(done), .STATUS_OUT(status), .RDAT_OUT(rdat),
        .SLV_RETRY_IN(retry));
    xbar_props xbar_props_i (.MCLK_IN(clk), .SYS_RST_IN(rst),
        .m_cyc(bus_link_i.m_cyc), .m_stb(bus_link_i.m_stb),
        .m_ack(bus_link_i.m_ack), .m_err(bus_link_i.m_err),
        .m_rty(bus_link_i.m_rty), .s_cyc(bus_link_i.s_cyc),
        .s_stb(bus_link_i.s_stb), .s_ack(bus_link_i.s_ack),
        .s_err(bus_link_i.s_err), .s_rty(bus_link_i.s_rty));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            failures++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmd(input int m, input logic w, input logic r,
                       input logic [3:0] n, input logic [ADR_W-1:0] a,
                       input logic [DAT_W-1:0] d);
        we[m] = w;
        rmw[m] = r;
        len[m] = n;
        adr[m] = a;
        wdat[m] = d;
    endtask

    // Starts the masters in mask, waits for their done pulses
    task automatic run(input logic [NUM_M-1:0] mask);
        logic [NUM_M-1:0] seen;
        seen = '0;
        maxp = '0;
        bseen = '0;
        @(posedge clk);
        #1;
        go = mask;
        for (int c = 0; c < 200 && seen != mask; c++) begin
            @(posedge clk);
            #1;
            go = '0;
            bseen = bseen | busy;
            if (pairs > maxp) begin
                maxp = pairs;
            end
            for (int m = 0; m < NUM_M; m++) begin
                if (done[m] === 1'b1) begin
                    seen[m] = 1'b1;
                    tdone[m] = c;
                end
            end
        end
        if (seen != mask) begin
            failures++;
            $display("Error at %0t: transfer never finished", $time);
            report_and_stop();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_single();
        for (int m = 0; m < NUM_M; m++) begin
            cmd(m, 1'b1, 1'b0, 4'h1, m ? 32'h8000_0008 : 32'h0000_0008,
                m ? P1 : P0);
            run(2'(1 << m));
            chk(status[m] === ST_OK, "write status");
            chk(bus_link_i.s_tag[m] === 1'b1, "tag");
            cmd(m, 1'b0, 1'b0, 4'h1, m ? 32'h8000_0008 : 32'h0000_0008, '0);
            run(2'(1 << m));
            chk(rdat[m] === (m ? P1 : P0), "read data");
        end
        $display("t_single finished");
    endtask

    task automatic t_parallel();
        cmd(0, 1'b1, 1'b0, 4'h4, 32'h0000_0010, P1);
        cmd(1, 1'b1, 1'b0, 4'h4, 32'h8000_0010, P0);
        run(2'b11);
        chk(tdone[0] == tdone[1], "pairs not concurrent");
        chk(maxp === 2'h2, "two live pairs not seen");
        chk(bseen === 2'b11, "both busy");
        $display("t_parallel finished");
    endtask

    // Two masters run RMW on one word; cycles must not interleave
    task automatic t_contend();
        int f;
        int l;
        logic [DAT_W-1:0] d [NUM_M];
        d[0] = 32'h1111_0000;
        d[1] = 32'h2222_0000;
        cmd(0, 1'b1, 1'b0, 4'h1, 32'h0000_0030, 32'h0000_0007);
        run(2'b01);
        cmd(0, 1'b0, 1'b1, 4'h0, 32'h0000_0030, d[0]);
        cmd(1, 1'b0, 1'b1, 4'h0, 32'h0000_0030, d[1]);
        run(2'b11);
        f = (tdone[0] < tdone[1]) ? 0 : 1;
        l = 1 - f;
        chk(tdone[0] != tdone[1], "shared slave granted twice");
        chk(rdat[f] === 32'h0000_0007, "first read-back");
        chk(rdat[l] === d[f], "second saw a split cycle");
        chk(owner[0] === MIDX_W'(l), "owner");
        cmd(0, 1'b0, 1'b0, 4'h1, 32'h0000_0030, '0);
        run(2'b01);
        chk(rdat[0] === d[l], "final semaphore value");
        $display("t_contend finished");
    endtask

    task automatic t_block();
        cmd(0, 1'b0, 1'b0, 4'h3, 32'h0000_0000, '0);
        run(2'b01);
        chk(status[0] === ST_OK, "block status");
        chk(rdat[0] === P0, "last block word");
        $display("t_block finished");
    endtask

    task automatic t_fault();
        cmd(0, 1'b0, 1'b0, 4'h1, 32'h0000_0040, '0);
        run(2'b01);
        chk(status[0] === ST_ERR, "error outcome");
        retry = 2'b10;
        cmd(1, 1'b0, 1'b0, 4'h1, 32'h8000_0008, '0);
        run(2'b10);
        chk(status[1] === ST_RTY, "retry outcome");
        retry = 2'b00;
        run(2'b10);
        chk(status[1] === ST_OK && rdat[1] === P1, "repeat");
        $display("t_fault finished");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        go = '0;
        we = '0;
        rmw = '0;
        len = '0;
        adr = '0;
        wdat = '0;
        sel = '1;
        tag = '1;
        retry = '0;
        failures = 0;
        tests_run = 0;
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        t_single();
        t_parallel();
        t_contend();
        t_block();
        t_fault();
        report_and_stop();
    end
endmodule
